// File: verilog/detector_cfg.svh
// How it works
// - Only receive line bits are watched, framed or unframed, with activate and deactivate codes tracked by two independent trackers.
// - Each tracker compares received bits with an 8-bit code register whose used length comes from a 2-bit length select.
// - In framed operation a configuration bit decides whether the framing bit enters the comparison or is skipped.
// - In unframed operation every received bit of the frame is compared.
// - Bit errors are counted only after four consecutive complete correct repetitions of the code.
// - A code is declared detected once more than 126 consecutive 39.8 ms periods each held fewer than 600 errors.
// - A period with more than 600 errors drops synchronisation and clears the detected bit.
// - A framing bit that is compared never counts as a bit error.
// - Any change of a detected bit sets its change flag.
// - The active-low interrupt output is asserted only for a set flag whose enable bit is one.
// - Software clears a change flag by writing one to it, and writing zero leaves it alone.
`ifndef DETECTOR_CFG_SVH
`define DETECTOR_CFG_SVH

// Register indices; byte address is four times the index
`define IDX_CONFIG 10'h076
`define IDX_STATE 10'h077
`define IDX_ACT_PAT 10'h078
`define IDX_DEACT_PAT 10'h079
`define IDX_IRQ_EN 10'h07a
`define IDX_IRQ_FLAGS 10'h07b

// Field positions
`define CFG_ACT_LEN_LSB 0
`define CFG_DEACT_LEN_LSB 2
`define CFG_FBIT_CMP 4
`define CFG_FRAMED 5
`define BIT_ACT 0
`define BIT_DEACT 1

// Reset values
`define RST_CONFIG 8'h20
`define RST_ACT_PAT 8'h00
`define RST_DEACT_PAT 8'h00
`define RST_IRQ_EN 8'h00

// Timing and thresholds
`define PERIOD_US 39800
`define LINE_KBPS 1544
`define PERIOD_BITS_CALC (`PERIOD_US * `LINE_KBPS / 1000)
`define GOOD_REPS 4
`define ERR_LIMIT 600
`define GOOD_PERIODS 126
`define MIN_LEN 5

`endif

// File: verilog/detector_pkg.sv
package detector_pkg;
	typedef enum logic [1:0] {st_search, st_verify, st_locked} track_state_t;
	typedef logic [7:0] byte_t;
endpackage

// File: verilog/code_tracker.sv
`timescale 1ns/1ps
`default_nettype none
`include "detector_cfg.svh"
module code_tracker
	import detector_pkg::*;
#(
	parameter int ERR_MAX = `ERR_LIMIT
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic bit_stb,
	input wire logic bit_val,
	input wire logic bit_fr,
	input wire logic [1:0] len_sel,
	input wire logic [7:0] pattern,
	input wire logic period_end,
	output logic detected
);
	track_state_t state;
	logic [7:0] hist;
	logic [2:0] phase;
	logic [2:0] rep_cnt;
	logic [9:0] err_cnt;
	logic [6:0] good_cnt;
	wire [7:0] next_hist = {hist[6:0], bit_val};
	wire [7:0] mask = 8'hff >> (2'd3 - len_sel);
	wire [2:0] last_phase = {1'b0, len_sel} + 3'h4;
	wire win_match = (next_hist & mask) == (pattern & mask);
	wire phase_wrap = phase == last_phase;
	wire [2:0] exp_idx = last_phase - phase;
	wire mismatch = bit_val != pattern[exp_idx];
	wire err_now = bit_stb && state == st_locked && mismatch && !bit_fr;
	wire [9:0] err_total = err_cnt + {9'h000, err_now};
	wire bad_period = err_total > 10'(ERR_MAX);
	wire good_period = err_total < 10'(ERR_MAX);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hist <= 8'h00;
		else if (bit_stb)
			hist <= next_hist;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= st_search;
			phase <= 3'h0;
			rep_cnt <= 3'h0;
		end
		else if (period_end && state == st_locked && bad_period)
		begin
			state <= st_search;
			rep_cnt <= 3'h0;
		end
		else if (bit_stb)
		begin
			phase <= phase_wrap ? 3'h0 : phase + 3'h1;
			case (state)
				st_search:
					if (win_match)
					begin
						state <= st_verify;
						rep_cnt <= 3'h1;
						phase <= 3'h0;
					end
				st_verify:
					if (phase_wrap)
					begin
						if (!win_match)
							state <= st_search;
						else if (rep_cnt == 3'(`GOOD_REPS - 1))
							state <= st_locked;
						rep_cnt <= win_match ? rep_cnt + 3'h1 : 3'h0;
					end
				st_locked: ;
				default: state <= st_search;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			err_cnt <= 10'h000;
			good_cnt <= 7'h00;
			detected <= 1'b0;
		end
		else if (period_end)
		begin
			err_cnt <= 10'h000;
			if (state != st_locked || !good_period)
				good_cnt <= 7'h00;
			else if (good_cnt != 7'h7f)
				good_cnt <= good_cnt + 7'h01;
			if (state == st_locked && bad_period)
				detected <= 1'b0;
			else if (state == st_locked && good_period && good_cnt == 7'(`GOOD_PERIODS))
				detected <= 1'b1;
		end
		else if (err_now && err_cnt != 10'h3ff)
			err_cnt <= err_cnt + 10'h001;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_lock_after_reps: assert property ($rose(state == st_locked) |-> $past(rep_cnt) == 3'h3)
		else $error("locked without four repetitions");
	a_detect_good_run: assert property ($rose(detected) |-> $past(good_cnt) == 7'd126)
		else $error("detected before enough good periods");
	a_drop_on_errors: assert property ((period_end && state == st_locked && bad_period)
		|=> !detected && state == st_search)
		else $error("sync not dropped after error period");
	a_fbit_no_error: assert property ((bit_stb && bit_fr && !period_end)
		|=> err_cnt == $past(err_cnt))
		else $error("framing bit counted as error");
	a_err_restart: assert property (period_end |=> err_cnt == 10'h000)
		else $error("error count not restarted");
	c_detect: cover property ($rose(detected));
	c_loss: cover property ($fell(detected));
endmodule // code_tracker
`default_nettype wire

// File: verilog/inband_loop_detector.sv
`timescale 1ns/1ps
`default_nettype none
`include "detector_cfg.svh"
module inband_loop_detector
	import detector_pkg::*;
#(
	parameter int PERIOD_BITS = `PERIOD_BITS_CALC,
	parameter int ERR_MAX = `ERR_LIMIT
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_line_clk,
	input wire logic rx_data,
	input wire logic rx_fbit,
	output logic irq_n
);
	byte_t config_reg;
	byte_t act_pat;
	byte_t deact_pat;
	logic [1:0] irq_en;
	logic [1:0] flags;
	logic [1:0] det_q;
	logic [1:0] detected;
	logic clk_s1, clk_s2, clk_s3;
	logic data_s1, data_s2;
	logic fbit_s1, fbit_s2;
	logic bit_stb, bit_val, bit_is_f;
	logic [15:0] period_cnt;
	logic period_end;

	// APB decode
	wire [9:0] idx = paddr[11:2];
	wire setup = psel && !penable;
	wire wr_done = psel && penable && pready && pwrite;
	wire hit_config = idx == `IDX_CONFIG;
	wire hit_state = idx == `IDX_STATE;
	wire hit_act = idx == `IDX_ACT_PAT;
	wire hit_deact = idx == `IDX_DEACT_PAT;
	wire hit_en = idx == `IDX_IRQ_EN;
	wire hit_flags = idx == `IDX_IRQ_FLAGS;
	wire mapped = hit_config | hit_state | hit_act | hit_deact | hit_en | hit_flags;
	wire [7:0] rd_byte =
		hit_config ? config_reg :
		hit_state ? {6'h00, detected} :
		hit_act ? act_pat :
		hit_deact ? deact_pat :
		hit_en ? {6'h00, irq_en} :
		hit_flags ? {6'h00, flags} : 8'h00;
	wire [1:0] changed = detected ^ det_q;
	wire [1:0] clr_req = (wr_done && hit_flags) ? pwdata[1:0] : 2'b00;
	wire [1:0] next_flags = (flags & ~clr_req) | changed;
	wire framed = config_reg[`CFG_FRAMED];
	wire fbit_cmp = config_reg[`CFG_FBIT_CMP];
	wire line_edge = clk_s2 && !clk_s3;
	wire f_here = framed && fbit_s2;
	wire compare_bit = !f_here || fbit_cmp;
	wire period_wrap = period_cnt == 16'(PERIOD_BITS - 1);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup && !mapped;
			prdata <= setup ? {24'h000000, rd_byte} : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			config_reg <= `RST_CONFIG;
			act_pat <= `RST_ACT_PAT;
			deact_pat <= `RST_DEACT_PAT;
			irq_en <= 2'(`RST_IRQ_EN);
		end
		else if (wr_done)
		begin
			if (hit_config)
				config_reg <= {2'b00, pwdata[5:0]};
			if (hit_act)
				act_pat <= pwdata[7:0];
			if (hit_deact)
				deact_pat <= pwdata[7:0];
			if (hit_en)
				irq_en <= pwdata[1:0];
		end
	end

	// change flags, set wins over clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flags <= 2'b00;
			det_q <= 2'b00;
		end
		else
		begin
			flags <= next_flags;
			det_q <= detected;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_n <= 1'b1;
		else
			irq_n <= ~|(flags & irq_en);
	end

	// Line inputs pass two flip-flops first
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clk_s1 <= 1'b0;
			clk_s2 <= 1'b0;
			clk_s3 <= 1'b0;
			data_s1 <= 1'b0;
			data_s2 <= 1'b0;
			fbit_s1 <= 1'b0;
			fbit_s2 <= 1'b0;
		end
		else
		begin
			clk_s1 <= rx_line_clk;
			clk_s2 <= clk_s1;
			clk_s3 <= clk_s2;
			data_s1 <= rx_data;
			data_s2 <= data_s1;
			fbit_s1 <= rx_fbit;
			fbit_s2 <= fbit_s1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bit_stb <= 1'b0;
			bit_val <= 1'b0;
			bit_is_f <= 1'b0;
		end
		else
		begin
			bit_stb <= line_edge && compare_bit;
			bit_val <= data_s2;
			bit_is_f <= f_here;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			period_cnt <= 16'h0000;
			period_end <= 1'b0;
		end
		else
		begin
			period_end <= line_edge && period_wrap;
			if (line_edge)
				period_cnt <= period_wrap ? 16'h0000 : period_cnt + 16'h0001;
		end
	end

	code_tracker #(.ERR_MAX(ERR_MAX)) u_act (
		.pclk(pclk),
		.presetn(presetn),
		.bit_stb(bit_stb),
		.bit_val(bit_val),
		.bit_fr(bit_is_f),
		.len_sel(config_reg[`CFG_ACT_LEN_LSB +: 2]),
		.pattern(act_pat),
		.period_end(period_end),
		.detected(detected[`BIT_ACT])
	);

	code_tracker #(.ERR_MAX(ERR_MAX)) u_deact (
		.pclk(pclk),
		.presetn(presetn),
		.bit_stb(bit_stb),
		.bit_val(bit_val),
		.bit_fr(bit_is_f),
		.len_sel(config_reg[`CFG_DEACT_LEN_LSB +: 2]),
		.pattern(deact_pat),
		.period_end(period_end),
		.detected(detected[`BIT_DEACT])
	);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_flag_on_change: assert property ($changed(detected[0]) |=> flags[0])
		else $error("activate change did not set flag");
	a_flag_w0_keeps: assert property ((wr_done && hit_flags && !pwdata[0] && flags[0])
		|=> flags[0])
		else $error("writing zero cleared a flag");
	a_flag_w1_clears: assert property ((wr_done && hit_flags && pwdata[1] && !changed[1])
		|=> !flags[1])
		else $error("writing one did not clear flag");
	a_irq_masked: assert property ((flags[0] && !irq_en[0] && !(flags[1] && irq_en[1])) [*2]
		|-> irq_n)
		else $error("interrupt asserted for masked flag");
	a_irq_raised: assert property ((flags & irq_en) != 2'b00 |=> !irq_n)
		else $error("interrupt not asserted");
	a_fbit_skipped: assert property ((line_edge && framed && fbit_s2 && !fbit_cmp)
		|=> !bit_stb)
		else $error("skipped framing bit was compared");
	a_apb_ready: assert property (setup |=> pready ##1 !pready || (psel && !penable))
		else $error("apb answer timing broken");

	a_unframed_all: assert property ((line_edge && !framed) |=> bit_stb)
		else $error("unframed bit was skipped");
	a_unframed_no_fbit: assert property ((line_edge && !framed) |=> !bit_is_f)
		else $error("framing marker used in unframed mode");
	a_fbit_compared: assert property ((line_edge && f_here && fbit_cmp)
		|=> bit_stb && bit_is_f)
		else $error("selected framing bit not compared");
	a_period_wrap: assert property ((line_edge && period_wrap)
		|=> period_end && period_cnt == 16'h0000)
		else $error("period boundary missed");
	a_no_stray_stb: assert property (!line_edge |=> !bit_stb && !period_end)
		else $error("strobe without line edge");
	a_flag_sticky: assert property ((flags[0] && !(wr_done && hit_flags && pwdata[0]))
		|=> flags[0])
		else $error("activate flag dropped without clear");
	a_flag_w1_act: assert property ((wr_done && hit_flags && pwdata[0] && !changed[0])
		|=> !flags[0])
		else $error("writing one did not clear activate flag");
	a_state_read: assert property ((setup && hit_state && !pwrite)
		|=> prdata == {30'h00000000, $past(detected)})
		else $error("status read does not show detection");
	a_irq_idle: assert property ((flags & irq_en) == 2'b00 |=> irq_n)
		else $error("interrupt asserted without enabled flag");
	a_irq_en_write: assert property ((wr_done && hit_en)
		|=> irq_en == $past(pwdata[1:0]))
		else $error("interrupt enable write lost");
	a_act_write: assert property ((wr_done && hit_act)
		|=> act_pat == $past(pwdata[7:0]))
		else $error("activate code write lost");
	a_deact_write: assert property ((wr_done && hit_deact)
		|=> deact_pat == $past(pwdata[7:0]))
		else $error("deactivate code write lost");
	a_config_write: assert property ((wr_done && hit_config)
		|=> config_reg[5:0] == $past(pwdata[5:0]))
		else $error("configuration write lost");
	// Unmapped write ignored
	a_unmapped_wr: assert property ((wr_done && !mapped) |=> config_reg == $past(config_reg)
		&& act_pat == $past(act_pat) && deact_pat == $past(deact_pat))
		else $error("unmapped write changed a register");
	// Unmapped access flagged
	a_unmapped_err: assert property ((setup && !mapped)
		|=> pready && pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not flagged");
	// One cycle answer
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready held too long");

	c_irq_low: cover property ($fell(irq_n));
	c_flag_clear: cover property (wr_done && hit_flags && flags != 2'b00);
	c_both_detected: cover property (detected == 2'b11);
endmodule // inband_loop_detector
`default_nettype wire

// File: tb/remote_loop_source.sv
`timescale 1ns/1ps
`default_nettype none
module remote_loop_source
(
	input wire logic [7:0] pat,
	input wire logic [3:0] len,
	input wire logic inj,
	output logic rx_line_clk,
	output logic rx_data,
	output logic rx_fbit
);
	int pos;
	int cnt;
	initial
	begin
		rx_line_clk = 0;
		rx_data = 0;
		rx_fbit = 0;
		pos = 0;
		cnt = 0;
		#3;
		forever
		begin
			#28 rx_line_clk = 1;
			#28 rx_line_clk = 0;
			cnt = (cnt + 1) % 193;
			rx_fbit = (cnt == 0);
			if (rx_fbit)
				rx_data = ~rx_data;
			else
			begin
				rx_data = pat[len - 1 - pos] ^ inj;
				pos = (pos + 1) % len;
			end
		end
	end
endmodule // remote_loop_source
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "detector_cfg.svh"
module tb_top import detector_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_n, inj, er;
	logic rx_line_clk, rx_data, rx_fbit;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [7:0] act_pat;
	logic [7:0] mdl [6];
	int error_cnt, samples_checked, n;
	inband_loop_detector #(.PERIOD_BITS(32), .ERR_MAX(12)) i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_line_clk(rx_line_clk),
		.rx_data(rx_data), .rx_fbit(rx_fbit), .irq_n(irq_n));
	remote_loop_source i_src (.pat(act_pat), .len(4'd8), .inj(inj),
		.rx_line_clk(rx_line_clk), .rx_data(rx_data), .rx_fbit(rx_fbit));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		chk(pready, 1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [9:0] i, input logic [7:0] v);
		apb(1, i, {24'h0, v});
		if (i == `IDX_IRQ_FLAGS)
			mdl[5] = mdl[5] & ~v;
		else if (i != `IDX_STATE)
			mdl[i - `IDX_CONFIG] = v;
	endtask
	task automatic rdc(input logic [9:0] i);
		apb(0, i, 32'h0);
		chk(rd, {24'h0, mdl[i - `IDX_CONFIG]});
		chk(er, 0);
	endtask
	task automatic report_and_stop();
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		pclk = 0;
		forever #2 pclk = ~pclk;
	end
	initial
	begin
		repeat (95000) @(posedge pclk);
		error_cnt++;
		report_and_stop();
	end
	initial
	begin
		presetn = 0;
		{psel, penable, pwrite, paddr, pwdata, inj} = '0;
		seed = 32'h00015cf3;
		act_pat = 8'h00;
		error_cnt = 0;
		samples_checked = 0;
		mdl = '{8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		repeat (6) @(posedge pclk);
		presetn <= 1;
		for (int i = 0; i < 6; i++)
			rdc(10'(`IDX_CONFIG + i));
		apb(1, 10'h07c, 32'hff);
		chk(er, 1);
		apb(0, 10'h07c, 32'h0);
		chk({er, rd}, {1'b1, 32'h0});
		wr(`IDX_STATE, 8'hff);
		rdc(`IDX_STATE);
		seed = lfsr(seed);
		act_pat <= seed[7:0] & 8'hbb;
		wr(`IDX_ACT_PAT, seed[7:0] & 8'hbb);
		wr(`IDX_DEACT_PAT, 8'h1f);
		wr(`IDX_CONFIG, 8'h23);
		wr(`IDX_IRQ_EN, 8'h01);
		for (int i = 0; i < 6; i++)
			rdc(10'(`IDX_CONFIG + i));
		n = 0;
		while (irq_n !== 1'b0 && n < 85000)
		begin
			@(posedge pclk);
			seed = lfsr(seed);
			inj <= (seed[4:0] == 5'h00);
			n++;
		end
		inj <= 0;
		mdl[1] = 8'h01;
		mdl[5] = 8'h01;
		chk(irq_n, 0);
		rdc(`IDX_STATE);
		rdc(`IDX_IRQ_FLAGS);
		wr(`IDX_IRQ_EN, 8'h00);
		repeat (3) @(posedge pclk);
		chk(irq_n, 1);
		wr(`IDX_IRQ_FLAGS, 8'h00);
		rdc(`IDX_IRQ_FLAGS);
		wr(`IDX_IRQ_EN, 8'h01);
		repeat (3) @(posedge pclk);
		chk(irq_n, 0);
		wr(`IDX_IRQ_FLAGS, 8'h01);
		repeat (3) @(posedge pclk);
		chk(irq_n, 1);
		rdc(`IDX_IRQ_FLAGS);
		rdc(`IDX_STATE);
		inj <= 1;
		n = 0;
		while (irq_n !== 1'b0 && n < 3000)
		begin
			@(posedge pclk);
			n++;
		end
		inj <= 0;
		mdl[1] = 8'h00;
		mdl[5] = 8'h01;
		chk(irq_n, 0);
		rdc(`IDX_STATE);
		rdc(`IDX_IRQ_FLAGS);
		wr(`IDX_CONFIG, 8'h03);
		repeat (40) @(posedge pclk);
		rdc(`IDX_CONFIG);
		wr(`IDX_CONFIG, 8'h33);
		repeat (2800) @(posedge pclk);
		rdc(`IDX_CONFIG);
		rdc(`IDX_STATE);
		rdc(`IDX_IRQ_FLAGS);
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
